/* rtl/archive_doc_record_gen.sv */
`timescale 1ns/1ps
module archive_doc_record_gen (
    // clock, reset, enable
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    // axi4-lite write address and data
    input  wire logic [3:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // receiver archive interface flags and panel pins
    input  wire doc_rec_pkg::rx_flags_t rx_flags,
    input  wire doc_rec_pkg::key_clr_t  key_clr,
    input  wire logic [23:0]            panel_sw,
    // recorder side
    input  wire logic                   track_recorded,
    output logic                        rec_line,
    output logic                        rec_busy
);
    logic [28:0]               sync_in;
    logic [28:0]               sync_out;
    logic [23:0]               sw_s;
    logic                      frame_s;
    logic                      sect_s;
    logic                      ir_s;
    logic                      day_s;
    logic                      tape_s;
    logic                      frame_prev_reg;
    logic                      sect_prev_reg;
    logic [6:0]                pic_reg;
    logic [16:0]               tape_reg;
    logic [3:0]                sector_reg;
    logic                      auto_reg;
    logic                      soft_start;
    logic                      soft_day;
    logic                      soft_tape;
    doc_rec_pkg::gen_state_t   state_reg;
    logic [8:0]                idx_reg;
    logic [0:191]              snap_reg;
    logic [0:191]              rec2;
    logic                      bit_data;
    logic                      bit_ready;
    logic                      bit_valid;
    logic                      start;
    logic                      wr_go;
    logic                      rd_go;
    logic [8:0]                rec2_pos;

    // every pin from outside this clock is settled first
    assign sync_in = {panel_sw, rx_flags.frame_flag, rx_flags.sector_code,
                      rx_flags.ir_present, key_clr.day_clear, key_clr.tape_clear};
    assign {sw_s, frame_s, sect_s, ir_s, day_s, tape_s} = sync_out;

    pin_sync #(
        .W       (doc_rec_pkg::SYNC_W)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin_in  (sync_in),
        .pin_out (sync_out)
    );

    // edge history of settled flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_prev_reg <= 1'b0;
            sect_prev_reg  <= 1'b0;
        end else if (ce) begin
            frame_prev_reg <= frame_s;
            sect_prev_reg  <= sect_s;
        end
    end

    // picture counter; clear beats a coinciding count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pic_reg <= 7'h00;
        end else if (ce) begin
            if (day_s || soft_day) begin
                pic_reg <= 7'h00;
            end else if (frame_s && !frame_prev_reg) begin
                pic_reg <= pic_reg + 7'h01;
            end
        end
    end

    // recorded track counter, wraps at 17 bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tape_reg <= 17'h00000;
        end else if (ce) begin
            if (tape_s || soft_tape) begin
                tape_reg <= 17'h00000;
            end else if (track_recorded) begin
                tape_reg <= tape_reg + 17'h00001;
            end
        end
    end

    // sector state: infrared pins it at zero, visible walks 1..8
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sector_reg <= doc_rec_pkg::SECT_IR;
        end else if (ce) begin
            if (ir_s) begin
                sector_reg <= doc_rec_pkg::SECT_IR;
            end else if (sect_s && !sect_prev_reg) begin
                if (sector_reg == doc_rec_pkg::SECT_VIS8) begin
                    sector_reg <= doc_rec_pkg::SECT_VIS1;
                end else begin
                    sector_reg <= sector_reg + 4'h1;
                end
            end
        end
    end

    // second record image, bit 1 at index 0
    assign rec2 = {pic_reg, tape_reg, sw_s,
                   {doc_rec_pkg::TIME_W{1'b1}},
                   {doc_rec_pkg::FILL_W{1'b1}},
                   sector_reg,
                   {doc_rec_pkg::TAIL_W{1'b0}}};

    // start when idle, from software or, in auto mode, on a recorded track
    assign start = ce && (state_reg == doc_rec_pkg::GEN_IDLE)
                   && (soft_start || (auto_reg && track_recorded));

    // generator sequencing; snapshot keeps fields steady while sending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= doc_rec_pkg::GEN_IDLE;
            idx_reg   <= 9'h000;
            snap_reg  <= '0;
        end else if (ce) begin
            case (state_reg)
                doc_rec_pkg::GEN_IDLE: begin
                    if (start) begin
                        state_reg <= doc_rec_pkg::GEN_SEND;
                        idx_reg   <= 9'h000;
                        snap_reg  <= rec2;
                    end
                end
                doc_rec_pkg::GEN_SEND: begin
                    if (bit_ready) begin
                        if (idx_reg == doc_rec_pkg::LAST_IDX) begin
                            state_reg <= doc_rec_pkg::GEN_IDLE;
                        end else begin
                            idx_reg <= idx_reg + 9'h001;
                        end
                    end
                end
                default: state_reg <= doc_rec_pkg::GEN_IDLE;
            endcase
        end
    end

    // first record alternates starting with 0, then the snapshot
    assign rec2_pos  = idx_reg - doc_rec_pkg::REC2_IDX;
    assign bit_data  = (idx_reg < doc_rec_pkg::REC2_IDX) ? idx_reg[0]
                                                         : snap_reg[rec2_pos[7:0]];
    assign bit_valid = (state_reg == doc_rec_pkg::GEN_SEND);
    assign rec_busy  = bit_valid;

    biphase_enc u_enc (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .bit_valid (bit_valid),
        .bit_data  (bit_data),
        .bit_ready (bit_ready),
        .line_out  (rec_line)
    );

    // axi write: address and data taken together, one at a time
    assign s_axi_awready = ce && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_go         = s_axi_awready;
    assign soft_start = wr_go && s_axi_awaddr == doc_rec_pkg::CTRL_OFS && s_axi_wstrb[0]
                        && s_axi_wdata[doc_rec_pkg::CTRL_START_BIT];
    assign soft_day   = wr_go && s_axi_awaddr == doc_rec_pkg::CTRL_OFS && s_axi_wstrb[0]
                        && s_axi_wdata[doc_rec_pkg::CTRL_DAY_BIT];
    assign soft_tape  = wr_go && s_axi_awaddr == doc_rec_pkg::CTRL_OFS && s_axi_wstrb[0]
                        && s_axi_wdata[doc_rec_pkg::CTRL_TAPE_BIT];

    // control register and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_reg     <= doc_rec_pkg::CTRL_AUTO_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= doc_rec_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr == doc_rec_pkg::CTRL_OFS) begin
                    s_axi_bresp <= doc_rec_pkg::RESP_OKAY;
                    if (s_axi_wstrb[0]) begin
                        auto_reg <= s_axi_wdata[doc_rec_pkg::CTRL_AUTO_BIT];
                    end
                end else begin
                    s_axi_bresp <= doc_rec_pkg::RESP_SLVERR; // others are read only
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign rd_go         = s_axi_arready && s_axi_arvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= doc_rec_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= doc_rec_pkg::RESP_OKAY;
                s_axi_rdata  <= 32'h00000000;
                case (s_axi_araddr)
                    doc_rec_pkg::CTRL_OFS: begin
                        s_axi_rdata[doc_rec_pkg::CTRL_AUTO_BIT] <= auto_reg;
                    end
                    doc_rec_pkg::STATUS_OFS: begin
                        s_axi_rdata[doc_rec_pkg::STAT_BUSY_BIT] <= rec_busy;
                        s_axi_rdata[doc_rec_pkg::STAT_SECT_LSB +: 4] <= sector_reg;
                        s_axi_rdata[doc_rec_pkg::STAT_FRAME_BIT] <= frame_s;
                    end
                    doc_rec_pkg::COUNT_OFS: begin
                        s_axi_rdata[6:0] <= pic_reg;
                        s_axi_rdata[doc_rec_pkg::CNT_TAPE_LSB +: 17] <= tape_reg;
                    end
                    doc_rec_pkg::SWITCH_OFS: begin
                        s_axi_rdata[23:0] <= sw_s;
                    end
                    default: s_axi_rresp <= doc_rec_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_first_alt: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_valid && idx_reg < doc_rec_pkg::REC2_IDX |-> bit_data == idx_reg[0])
        else $error("first record pattern broken");

    a_pic_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && day_s |=> pic_reg == 7'h00)
        else $error("picture counter not cleared");

    a_pic_count: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !day_s && !soft_day && frame_s && !frame_prev_reg
        |=> pic_reg == $past(pic_reg) + 7'h01)
        else $error("frame rise not counted");

    a_tape_count: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !tape_s && !soft_tape && track_recorded
        |=> tape_reg == $past(tape_reg) + 17'h00001)
        else $error("track not counted");

    a_ir_sector: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ir_s |=> sector_reg == doc_rec_pkg::SECT_IR)
        else $error("infrared did not force sector zero");

    a_sector_range: assert property (@(posedge aclk) disable iff (!aresetn)
        sector_reg <= doc_rec_pkg::SECT_VIS8)
        else $error("sector identifier out of range");

    a_fill_ones: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_valid |-> snap_reg[48:91] == {44{1'b1}})
        else $error("fill field not all ones");

    a_tail_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_valid && idx_reg >= 9'h120 |-> bit_data == 1'b0)
        else $error("trailing field not zero");

    a_rec_length: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && bit_valid && bit_ready && idx_reg == doc_rec_pkg::LAST_IDX
        |=> !bit_valid)
        else $error("record pair length wrong");
endmodule : archive_doc_record_gen

/* rtl/biphase_enc.sv */
`timescale 1ns/1ps
module biphase_enc (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // bit stream in
    input  wire logic bit_valid,
    input  wire logic bit_data,
    output logic      bit_ready,
    // encoded line
    output logic      line_out
);
    logic       active_reg;
    logic       cur_reg;
    logic [3:0] cnt_reg;
    logic       take;

    // a new bit may start only at the end of the current interval
    assign bit_ready = !active_reg || (cnt_reg == doc_rec_pkg::BIT_LAST);
    assign take      = ce && bit_valid && bit_ready;

    // interval timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_reg <= 1'b0;
            cur_reg    <= 1'b0;
            cnt_reg    <= 4'h0;
        end else if (take) begin
            active_reg <= 1'b1;
            cur_reg    <= bit_data;
            cnt_reg    <= 4'h0;
        end else if (ce && active_reg) begin
            if (cnt_reg == doc_rec_pkg::BIT_LAST) begin
                active_reg <= 1'b0; // stream ran dry, line rests
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    // line level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_out <= 1'b0;
        end else if (take) begin
            line_out <= !line_out;
        end else if (ce && active_reg && cur_reg && cnt_reg == doc_rec_pkg::HALF_AT) begin
            line_out <= !line_out;
        end
    end

    a_zero_flat: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && active_reg && !cur_reg && cnt_reg != doc_rec_pkg::BIT_LAST && !take
        |=> $stable(line_out))
        else $error("zero bit changed level mid interval");

    a_one_mid: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && active_reg && cur_reg && cnt_reg == doc_rec_pkg::HALF_AT
        |=> line_out != $past(line_out))
        else $error("one bit missed mid interval transition");

    a_edge_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        take |=> line_out != $past(line_out))
        else $error("no transition at bit boundary");
endmodule : biphase_enc

/* rtl/doc_rec_pkg.sv */
package doc_rec_pkg;

    // bus register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] COUNT_OFS  = 4'h8;
    localparam logic [3:0] SWITCH_OFS = 4'hc;

    // control field positions
    localparam int CTRL_AUTO_BIT  = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_DAY_BIT   = 2;
    localparam int CTRL_TAPE_BIT  = 3;
    localparam logic CTRL_AUTO_RST = 1'b0;

    // status and count field positions
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_SECT_LSB  = 4;
    localparam int STAT_FRAME_BIT = 8;
    localparam int CNT_TAPE_LSB   = 8;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // record layout
    localparam int REC_BITS    = 192;
    localparam int PIC_W       = 7;
    localparam int TAPE_W      = 17;
    localparam int SW_W        = 24;
    localparam int TIME_W      = 24;
    localparam int FILL_W      = 20;
    localparam int SECT_W      = 4;
    localparam int TAIL_W      = 96;
    localparam int TOTAL_BITS  = 384;
    localparam logic [8:0] LAST_IDX = 9'h17f;
    localparam logic [8:0] REC2_IDX = 9'h0c0;

    // sector identifier codes
    localparam logic [3:0] SECT_IR   = 4'h0;
    localparam logic [3:0] SECT_VIS1 = 4'h1;
    localparam logic [3:0] SECT_VIS8 = 4'h8;

    // line timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BIT_NS         = 140;
    localparam int ZERO_PERIOD_NS = 280;
    localparam int BIT_CYC  = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC = (BIT_NS / 2) / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);
    localparam logic [3:0] HALF_AT  = 4'(HALF_CYC - 1);

    // synchroniser width: switches, frame, sector code, ir, two keyed clears
    localparam int SYNC_W = 29;

    // flags from the receiver archive interface
    typedef struct packed {
        logic frame_flag;
        logic sector_code;
        logic ir_present;
    } rx_flags_t;

    // keyed front panel clears
    typedef struct packed {
        logic day_clear;
        logic tape_clear;
    } key_clr_t;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_SEND = 2'b01
    } gen_state_t;

endpackage : doc_rec_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // asynchronous pins and their settled copies
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // three stage chain per bit; first stage feeds only the second
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                s1_reg[g]  <= 1'b0;
                s2_reg[g]  <= 1'b0;
                s3_reg[g]  <= 1'b0;
                pin_out[g] <= 1'b0;
            end else if (ce) begin
                s1_reg[g] <= pin_in[g];
                s2_reg[g] <= s1_reg[g];
                s3_reg[g] <= s2_reg[g];
                // a change counts only once two stages agree
                if (s2_reg[g] == s3_reg[g]) begin
                    pin_out[g] <= s3_reg[g];
                end
            end
        end
    end
endmodule : pin_sync

/* testbench/rec_model.sv */
`timescale 1ns/1ps
module rec_model (
    // clock and reset
    input  wire logic    aclk,
    input  wire logic    aresetn,
    // line from the block, track request
    input  wire logic    rec_line,
    input  wire logic    rec_busy,
    input  wire logic    trk_req,
    output logic         track_recorded,
    // decoded pair and line faults
    output logic [0:383] rx_bits,
    output int           nbits,
    output int           bnd_err
);
    int   ph;
    logic lvl_a;
    logic lvl_b;
    logic started;
    // one pulse per track the tape writes with data
    always_ff @(posedge aclk) begin
        track_recorded <= aresetn & trk_req;
    end
    // sample each 14-cycle cell early and late; a change inside the cell is a one
    always_ff @(posedge aclk) begin
        // busy drops as the last bit starts, so a started pair runs on to its last cell
        if (!aresetn || (!rec_busy && !started)) begin
            ph      <= 1;
            started <= 1'b0;
            if (!aresetn) begin
                bnd_err <= 0;
                nbits   <= 0;
            end
        end else begin
            ph <= (ph == 14) ? 1 : ph + 1;
            if (ph == 3) begin
                lvl_a   <= rec_line;
                started <= 1'b1;
                if (!started) nbits <= 0;
                if (started && rec_line == lvl_b) bnd_err <= bnd_err + 1;
            end
            if (ph == 10 && nbits < 384) begin
                rx_bits[nbits] <= (rec_line != lvl_a);
                lvl_b          <= rec_line;
                nbits          <= nbits + 1;
                if (nbits == 383) started <= 1'b0; // pair complete
            end
        end
    end
endmodule : rec_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic        wr;
        logic [3:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic [1:0]  resp;
    } row_t;
    logic                   aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]             awaddr = 4'h0, araddr = 4'h0;
    logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                   arvalid = 1'b0, rready = 1'b0, trk_req = 1'b0;
    logic [31:0]            wdata = 32'h0, rdata;
    logic                   awready, wready, bvalid, arready, rvalid;
    logic [1:0]             bresp, rresp, r;
    logic [31:0]            d;
    doc_rec_pkg::rx_flags_t flags = 3'h0;
    doc_rec_pkg::key_clr_t  keys = 2'h0;
    logic [23:0]            panel = 24'ha5c3f0;
    logic                   track_recorded, rec_line, rec_busy;
    logic [0:383]           rx_bits;
    int                     nbits, bnd_err, n_fail = 0, check_count = 0, cyc = 0;
    row_t                   rows [8];

    always #5 aclk = ~aclk;

    archive_doc_record_gen u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_flags(flags), .key_clr(keys),
        .panel_sw(panel), .track_recorded(track_recorded), .rec_line(rec_line),
        .rec_busy(rec_busy));
    rec_model u_rec (.aclk(aclk), .aresetn(aresetn), .rec_line(rec_line),
        .rec_busy(rec_busy), .trk_req(trk_req), .track_recorded(track_recorded),
        .rx_bits(rx_bits), .nbits(nbits), .bnd_err(bnd_err));

    task automatic results;
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // hang guard: two pairs plus setup stay well below this
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1; // must count before the verdict reads it
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // address and data offered together, held until taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata; rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // pins pass a synchroniser, so pulses are held well past its latency
    task automatic pin(input logic [2:0] m, input int n);
        repeat (n) begin
            flags <= flags | m;
            repeat (8) @(posedge aclk);
            flags <= flags & ~m;
            repeat (8) @(posedge aclk);
        end
    endtask : pin
    task automatic trk;
        trk_req <= 1'b1;
        @(posedge aclk);
        trk_req <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : trk
    task automatic wait_busy(input logic lvl);
        while (rec_busy !== lvl) @(posedge aclk);
    endtask : wait_busy
    task automatic rec_chk(input logic [6:0] p, input logic [16:0] t, input logic [3:0] s);
        chk("nbits", 32'(nbits), 32'h180);
        chk("bnd_err", 32'(bnd_err), 32'h0);
        for (int i = 0; i < 6; i++) chk("rec1", rx_bits[i*32 +: 32], 32'h55555555);
        chk("pic", 32'(rx_bits[192:198]), 32'(p));
        chk("track", 32'(rx_bits[199:215]), 32'(t));
        chk("switch", 32'(rx_bits[216:239]), 32'(panel));
        chk("time", 32'(rx_bits[240:263]), 32'h00ffffff);
        chk("fill", 32'(rx_bits[264:283]), 32'h000fffff);
        chk("sector", 32'(rx_bits[284:287]), 32'(s));
        for (int i = 0; i < 3; i++) chk("tail", rx_bits[288+i*32 +: 32], 32'h0);
    endtask : rec_chk

    initial begin
        rows[0] = {1'b1, 4'h0, 32'h0, 32'h0, 2'b00};
        rows[1] = {1'b0, 4'h0, 32'h0, 32'h0, 2'b00};
        rows[2] = {1'b1, 4'h4, 32'h1, 32'h0, 2'b10};
        rows[3] = {1'b1, 4'h8, 32'h1, 32'h0, 2'b10};
        rows[4] = {1'b0, 4'hc, 32'h0, 32'h00a5c3f0, 2'b00};
        rows[5] = {1'b0, 4'h8, 32'h0, 32'h0, 2'b00};
        rows[6] = {1'b0, 4'h2, 32'h0, 32'h0, 2'b10};
        rows[7] = {1'b0, 4'h4, 32'h0, 32'h0, 2'b00};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("line_rst", {30'h0, rec_line, rec_busy}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            if (rows[i].wr) axi_wr(rows[i].addr, rows[i].data, r);
            else axi_rd(rows[i].addr, d, r);
            if (!rows[i].wr) chk("rdata", d, rows[i].exp);
            chk("resp", 32'(r), 32'(rows[i].resp));
        end
        // counts and sector, then a software-started pair
        pin(3'b100, 3);
        repeat (5) trk();
        pin(3'b010, 2);
        axi_rd(4'h8, d, r);
        chk("count", d, 32'h00000503);
        axi_wr(4'h0, 32'h2, r);
        wait_busy(1'b1);
        wait_busy(1'b0);
        // the last cell is sampled nine cycles after busy drops
        repeat (12) @(posedge aclk);
        rec_chk(7'h3, 17'h5, 4'h2);
        // infrared forces sector zero, visible steps 1..8 then wraps to 1
        flags.ir_present <= 1'b1;
        repeat (8) @(posedge aclk);
        axi_rd(4'h4, d, r);
        chk("sect_ir", d & 32'hf0, 32'h0);
        flags.ir_present <= 1'b0;
        // let the release land before the pulse task rewrites the flags
        repeat (8) @(posedge aclk);
        pin(3'b010, 8);
        axi_rd(4'h4, d, r);
        chk("sect_v8", d & 32'hf0, 32'h80);
        pin(3'b010, 1);
        // keyed day clear, soft track clear, then picture count wrap
        keys.day_clear <= 1'b1;
        repeat (8) @(posedge aclk);
        keys.day_clear <= 1'b0;
        axi_wr(4'h0, 32'h8, r);
        repeat (8) @(posedge aclk);
        axi_rd(4'h8, d, r);
        chk("cleared", d, 32'h0);
        pin(3'b100, 129);
        // auto start on a track, a second start while busy is ignored
        axi_wr(4'h0, 32'h1, r);
        trk();
        wait_busy(1'b1);
        axi_wr(4'h0, 32'h3, r);
        wait_busy(1'b0);
        repeat (20) @(posedge aclk);
        chk("busy_idle", {31'h0, rec_busy}, 32'h0);
        // snapshot is taken before the starting track is counted
        rec_chk(7'h1, 17'h0, 4'h1);
        axi_rd(4'h8, d, r);
        chk("count2", d, 32'h00000101);
        results();
    end
endmodule : tb_top
